//--- rtl/ddc_pkg.sv
// Constants, types and helpers of the dual converter input and control port.
// Assumes one 20 MHz APB clock and pins that are asynchronous to it.
// Notes on behaviour
// - The control word is taken from the channel A bus when the control strobe falls.
// - Bus bit 9 of a control word is the shutdown bit and forces power-down when set.
// - Bus bit 8 is the converter enable bit; with shutdown clear, 0 means standby and 1 run.
// - Bus bit 7 enables the second filter stage for fourfold mode, legal only with stage one.
// - Bus bit 6 enables the first filter stage; 0 means no interpolation, 1 means twofold.
// - Bus bits 5 to 2 carry the channel A gain trim word, bit 5 most significant.
// - With interleave select high both channels are sampled from the channel A bus.
// - With interleave select low, A is latched on the data clock rise and B on its fall.
// - After reset: no interpolation, zero gain trim, converter fully running.
// - The gain trim moves channel A gain in equal steps, code 0 highest, code 15 lowest.
// - Samples are registered on a data clock edge (A on the rise, B on the fall) and reach the output on the next rise.
`default_nettype none
package ddc_pkg;
    localparam int DATA_W = 10;
    localparam int CTRL_MSB = 9;
    localparam int CTRL_LSB = 2;
    localparam int CTRL_W = CTRL_MSB - CTRL_LSB + 1;

    typedef struct packed {
        logic shutdown_bit;
        logic converter_enable_bit;
        logic second_filter_enable;
        logic first_filter_enable;
        logic [3:0] gain_trim;
    } ddc_ctrl_t;

    typedef enum logic [1:0] {
        INTERP_NONE = 2'h0,
        INTERP_X2 = 2'h1,
        INTERP_X4 = 2'h3
    } ddc_interp_t;

    typedef enum logic [1:0] {
        PWR_ACTIVE = 2'h0,
        PWR_STANDBY = 2'h1,
        PWR_SHUTDOWN = 2'h3
    } ddc_power_t;

    localparam ddc_ctrl_t CTRL_RESET = '{1'b0, 1'b1, 1'b0, 1'b0, 4'h8};
    localparam logic [4:0] GAIN_ZERO_CODE = 5'h08;

    localparam int PADDR_W = 12;
    localparam logic [PADDR_W-1:0] REG_CONTROL = 12'h000;
    localparam logic [PADDR_W-1:0] REG_STATUS = 12'h004;
    localparam logic [PADDR_W-1:0] REG_CLOCK_DIV = 12'h008;
    localparam logic [PADDR_W-1:0] REG_SAMPLES = 12'h00C;
    localparam int ST_ILLEGAL = 0;
    localparam int ST_SETTLED = 1;
    localparam int ST_POWER_LSB = 2;
    localparam int ST_MODE_LSB = 4;
    localparam int SAMPLE_B_LSB = 16;
    localparam int DIV_W = 8;
    localparam logic [DIV_W-1:0] DIV_RESET = 8'h00;

    localparam real CLK_MHZ = 20.0;
    localparam real WAKE_TIME_US = 0.7;
    localparam real SHUTDOWN_SETTLE_MS = 0.5;
    // Small margin keeps float error from adding a cycle
    localparam int WAKE_CYCLES = int'($ceil(WAKE_TIME_US * CLK_MHZ - 1.0e-6));
    localparam int SHUTDOWN_SETTLE_CYCLES =
        int'($ceil(SHUTDOWN_SETTLE_MS * 1000.0 * CLK_MHZ - 1.0e-6));
    localparam int SETTLE_W = 14;

    function automatic ddc_interp_t interp_of(input ddc_ctrl_t c);
        if (c.first_filter_enable && c.second_filter_enable)
            return INTERP_X4;
        else if (c.first_filter_enable)
            return INTERP_X2;
        else
            return INTERP_NONE;
    endfunction

    function automatic ddc_power_t power_of(input ddc_ctrl_t c);
        if (c.shutdown_bit)
            return PWR_SHUTDOWN;
        else if (!c.converter_enable_bit)
            return PWR_STANDBY;
        else
            return PWR_ACTIVE;
    endfunction

    function automatic logic [4:0] gain_steps_of(input logic [3:0] code);
        return 5'(GAIN_ZERO_CODE - {1'b0, code});
    endfunction
endpackage
`default_nettype wire

//--- rtl/ddc_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes pins asynchronous to clk; a bit changes once stages two and three agree.
`default_nettype none
module ddc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    if (WIDTH < 1)
        $error("WIDTH must be at least 1");

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level <= '0;
        end
        else
        begin
            stage1 <= pin;
            stage2 <= stage1;
            stage3 <= stage2;
            level <= (stage2 & stage3) | (level & (stage2 | stage3));
        end
    end
endmodule // ddc_sync
`default_nettype wire

//--- rtl/ddc_top.sv
// Input and control port of a dual converter, with an APB register slave.
// Assumes host-driven pins asynchronous to pclk and an APB master on pclk.
//
// Our own choices: the register addresses and the APB register port.
`default_nettype none
module ddc_top
    import ddc_pkg::*;
#(
    parameter int OFF_SETTLE_CYCLES = SHUTDOWN_SETTLE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic [DATA_W-1:0] channel_a_bus,
    input wire logic [DATA_W-1:0] channel_b_bus,
    input wire logic control_word_strobe_n,
    input wire logic interleave_select,
    output logic data_clock_out,
    output logic [DATA_W-1:0] sample_a_out,
    output logic [DATA_W-1:0] sample_b_out,
    output ddc_interp_t interp_mode_out,
    output ddc_power_t power_state_out,
    output logic [3:0] gain_trim_out,
    output logic [4:0] gain_a_steps,
    output logic output_settled
);
    localparam int PIN_W = 2 * DATA_W + 2;
    localparam int WAKE_MAX = WAKE_CYCLES + 2;

    if (DATA_W < CTRL_MSB + 1)
        $error("Channel A bus too narrow for the control word");
    if (OFF_SETTLE_CYCLES < 1 || OFF_SETTLE_CYCLES >= (1 << SETTLE_W))
        $error("OFF_SETTLE_CYCLES out of counter range");

    logic [PIN_W-1:0] pin_level;
    logic [DATA_W-1:0] a_now;
    logic [DATA_W-1:0] b_now;
    logic strobe_now;
    logic ileave_now;
    logic strobe_prev;
    logic strobe_fall;
    ddc_ctrl_t pin_word;
    ddc_ctrl_t wr_word;
    ddc_ctrl_t ctrl;
    logic illegal_seen;
    logic [DIV_W-1:0] clock_div;
    logic [DIV_W-1:0] div_cnt;
    logic tick;
    logic [DATA_W-1:0] hold_a;
    logic [DATA_W-1:0] hold_b;
    ddc_power_t power_prev;
    logic [SETTLE_W-1:0] settle_cnt;
    logic access;
    logic done;
    logic wr_control;
    logic wr_status;
    logic wr_div;
    logic mapped;
    logic [31:0] next_rdata;

    // Forbidden filter setting: second stage on, first stage off
    function automatic logic illegal_of(input ddc_ctrl_t c);
        return c.second_filter_enable && !c.first_filter_enable;
    endfunction

    // Strobe enters inverted so the synchroniser reset level matches the idle pin
    ddc_sync #(
        .WIDTH(PIN_W)
    ) u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .pin({interleave_select, ~control_word_strobe_n, channel_b_bus, channel_a_bus}),
        .level(pin_level)
    );

    assign a_now = pin_level[DATA_W-1:0];
    assign b_now = pin_level[2*DATA_W-1:DATA_W];
    assign strobe_now = pin_level[2*DATA_W];
    assign ileave_now = pin_level[2*DATA_W+1];
    assign strobe_fall = strobe_now & ~strobe_prev;
    // Bits 1 and 0 never reach the control word
    assign pin_word = ddc_ctrl_t'(a_now[CTRL_MSB:CTRL_LSB]);
    assign wr_word = ddc_ctrl_t'(pwdata[CTRL_W-1:0]);

    // APB handshake, one wait state per access
    assign access = psel & penable;
    assign done = access & pready;
    assign wr_control = done & pwrite & (paddr == REG_CONTROL);
    assign wr_status = done & pwrite & (paddr == REG_STATUS);
    assign wr_div = done & pwrite & (paddr == REG_CLOCK_DIV);
    assign mapped = (paddr == REG_CONTROL) || (paddr == REG_STATUS) ||
        (paddr == REG_CLOCK_DIV) || (paddr == REG_SAMPLES);

    always_comb
    begin
        next_rdata = '0;
        unique case (paddr)
            REG_CONTROL: next_rdata[CTRL_W-1:0] = ctrl;
            REG_STATUS:
            begin
                next_rdata[ST_ILLEGAL] = illegal_seen;
                next_rdata[ST_SETTLED] = output_settled;
                next_rdata[ST_POWER_LSB +: 2] = power_state_out;
                next_rdata[ST_MODE_LSB +: 2] = interp_mode_out;
            end
            REG_CLOCK_DIV: next_rdata[DIV_W-1:0] = clock_div;
            REG_SAMPLES:
            begin
                next_rdata[DATA_W-1:0] = sample_a_out;
                next_rdata[SAMPLE_B_LSB +: DATA_W] = sample_b_out;
            end
            default: next_rdata = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= '0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= access & ~pready;
            if (access && !pready)
            begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
                pslverr <= ~mapped;
            end
            else
            begin
                pslverr <= 1'b0;
            end
        end
    end

    // Control word store; the pin strobe wins over a same-cycle bus write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strobe_prev <= 1'b0;
            ctrl <= CTRL_RESET;
        end
        else
        begin
            strobe_prev <= strobe_now;
            if (strobe_fall)
                ctrl <= pin_word;
            else if (wr_control)
                ctrl <= wr_word;
        end
    end

    // Sticky flag for the forbidden filter setting; a new event beats the clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            illegal_seen <= 1'b0;
        else if (strobe_fall && illegal_of(pin_word))
            illegal_seen <= 1'b1;
        else if (!strobe_fall && wr_control && illegal_of(wr_word))
            illegal_seen <= 1'b1;
        else if (wr_status && pwdata[ST_ILLEGAL])
            illegal_seen <= 1'b0;
    end

    // Decoded mode outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interp_mode_out <= INTERP_NONE;
            power_state_out <= PWR_ACTIVE;
            gain_trim_out <= CTRL_RESET.gain_trim;
            gain_a_steps <= 5'h00;
        end
        else
        begin
            interp_mode_out <= interp_of(ctrl);
            power_state_out <= power_of(ctrl);
            gain_trim_out <= ctrl.gain_trim;
            gain_a_steps <= gain_steps_of(ctrl.gain_trim);
        end
    end

    // Settling timer after wake from standby or shutdown
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            power_prev <= PWR_ACTIVE;
            settle_cnt <= '0;
            output_settled <= 1'b1;
        end
        else
        begin
            power_prev <= power_state_out;
            if (power_state_out != PWR_ACTIVE)
            begin
                settle_cnt <= '0;
                output_settled <= 1'b0;
            end
            else if (power_prev == PWR_STANDBY)
            begin
                settle_cnt <= SETTLE_W'(WAKE_CYCLES);
                output_settled <= 1'b0;
            end
            else if (power_prev == PWR_SHUTDOWN)
            begin
                settle_cnt <= SETTLE_W'(OFF_SETTLE_CYCLES);
                output_settled <= 1'b0;
            end
            else if (settle_cnt != '0)
            begin
                settle_cnt <= settle_cnt - 1'b1;
                output_settled <= (settle_cnt == 1);
            end
        end
    end

    // Clock divider register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clock_div <= DIV_RESET;
        else if (wr_div)
            clock_div <= pwdata[DIV_W-1:0];
    end

    // Data clock: toggles every clock_div + 1 pclk cycles
    assign tick = (div_cnt >= clock_div);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_cnt <= '0;
            data_clock_out <= 1'b0;
        end
        else if (tick)
        begin
            div_cnt <= '0;
            data_clock_out <= ~data_clock_out;
        end
        else
        begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // Sample capture on data clock edges, output register on the next rise
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            hold_a <= '0;
            hold_b <= '0;
            sample_a_out <= '0;
            sample_b_out <= '0;
        end
        else if (tick && !data_clock_out)
        begin
            hold_a <= a_now;
            sample_a_out <= hold_a;
            sample_b_out <= hold_b;
        end
        else if (tick && data_clock_out)
        begin
            hold_b <= ileave_now ? a_now : b_now;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_strobe_capture: assert property (strobe_fall |=> ctrl == $past(pin_word))
        else $error("control word not taken on strobe fall");
    a_shutdown_wins: assert property (
        strobe_fall && pin_word.shutdown_bit |=> ##1 power_state_out == PWR_SHUTDOWN)
        else $error("shutdown bit did not force power-down");
    a_standby_entry: assert property (
        strobe_fall && !pin_word.shutdown_bit && !pin_word.converter_enable_bit
        |=> ##1 power_state_out == PWR_STANDBY)
        else $error("enable bit low did not give standby");
    a_fourfold_mode: assert property (
        strobe_fall && pin_word.second_filter_enable && pin_word.first_filter_enable
        |=> ##1 interp_mode_out == INTERP_X4)
        else $error("fourfold mode not selected");
    a_first_stage: assert property (
        strobe_fall && !pin_word.second_filter_enable |=> ##1
        interp_mode_out == ($past(pin_word.first_filter_enable, 2) ? INTERP_X2 : INTERP_NONE))
        else $error("first stage mode wrong");
    a_gain_field: assert property (
        strobe_fall |=> ##1 gain_trim_out == $past(a_now[CTRL_LSB +: 4], 2))
        else $error("gain trim not from bits 5 to 2");
    a_interleave_b: assert property (
        tick && data_clock_out && ileave_now |=> hold_b == $past(a_now))
        else $error("interleaved B sample not from A bus");
    a_split_b: assert property (
        tick && data_clock_out && !ileave_now |=> hold_b == $past(b_now))
        else $error("B sample not taken on data clock fall");
    a_wake_wait: assert property (
        power_state_out == PWR_ACTIVE && power_prev == PWR_STANDBY
        |=> !output_settled [*8] ##[1:WAKE_MAX] output_settled)
        else $error("wake settle time wrong");
    a_illegal_flag: assert property (
        (strobe_fall && illegal_of(pin_word)) ||
        (!strobe_fall && wr_control && illegal_of(wr_word))
        |=> illegal_seen)
        else $error("forbidden filter setting not flagged");
    a_gain_steps: assert property (
        $changed(gain_trim_out) |-> 5'(gain_a_steps - $past(gain_a_steps))
        == 5'({1'b0, $past(gain_trim_out)} - {1'b0, gain_trim_out}))
        else $error("gain step not uniform with trim code");
    a_sample_pipe: assert property (
        tick && !data_clock_out |=> hold_a == $past(a_now) && sample_a_out == $past(hold_a))
        else $error("sample pipeline wrong");
    a_apb_answer: assert property (access && !pready |=> pready)
        else $error("APB access not answered");
endmodule // ddc_top
`default_nettype wire

//--- verif/ddc_host_model.sv
// Host logic model driving the sample buses and the control strobe.
// Assumes the bench calls its tasks just after a rising edge of clk.
`default_nettype none
module ddc_host_model
    import ddc_pkg::*;
(
    input wire logic clk,
    output logic [DATA_W-1:0] bus_a,
    output logic [DATA_W-1:0] bus_b,
    output logic strobe_n,
    output logic ileave
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        bus_a = 10'h000;
        bus_b = 10'h000;
        strobe_n = 1'b1;
        ileave = 1'b0;
    end

    // Word held well before and after the strobe fall
    task automatic ctrl_write(input logic [7:0] word);
        bus_a <= {word, 2'h3};
        repeat (6) @(posedge clk);
        strobe_n <= 1'b0;
        repeat (4) @(posedge clk);
        strobe_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    // Both channels over bus A when interleaving
    task automatic samples(input logic [9:0] a, input logic [9:0] b, input logic il);
        bus_a <= a;
        bus_b <= b;
        ileave <= il;
    endtask
endmodule // ddc_host_model
`default_nettype wire

//--- verif/ddc_top_tb.sv
// Self-checking bench of the converter port: APB master and host pins.
// Assumes ddc_top and ddc_host_model are compiled before it.
`default_nettype none
module ddc_top_tb
    import ddc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SIM_SETTLE = 20;
    localparam int LIMIT = 20000;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dclk, settled, e;
    logic [PADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [DATA_W-1:0] bus_a, bus_b, out_a, out_b;
    logic strobe_n, ileave;
    ddc_interp_t mode, em;
    ddc_power_t pwr, ep;
    logic [3:0] trim;
    logic [4:0] steps;
    logic [7:0] w;
    logic [7:0] words [6] = '{8'h03, 8'h5F, 8'h70, 8'hC5, 8'h80, 8'h48};
    int err_total, checks_done, cyc;

    ddc_top #(.OFF_SETTLE_CYCLES(SIM_SETTLE)) ddc_top_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .channel_a_bus(bus_a),
        .channel_b_bus(bus_b), .control_word_strobe_n(strobe_n),
        .interleave_select(ileave), .data_clock_out(dclk), .sample_a_out(out_a),
        .sample_b_out(out_b), .interp_mode_out(mode), .power_state_out(pwr),
        .gain_trim_out(trim), .gain_a_steps(steps), .output_settled(settled));

    ddc_host_model ddc_host_model_inst (.clk(pclk), .bus_a(bus_a), .bus_b(bus_b),
        .strobe_n(strobe_n), .ileave(ileave));

    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Setup, access, then hold until pready is sampled high
    task automatic apb(input logic wr, input logic [PADDR_W-1:0] a, input logic [31:0] wd,
                       output logic [31:0] r, output logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge pclk);
            n++;
        end
        chk("pready", pready, 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            err_total++;
            complete_run();
        end
    end

    initial
    begin
        err_total = 0;
        checks_done = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("rst mode", mode, INTERP_NONE);
        chk("rst power", pwr, PWR_ACTIVE);
        chk("rst steps", steps, 5'h00);
        apb(1'b0, REG_CONTROL, 32'h0, rd, e);
        chk("rst ctrl", rd, 32'h48);
        for (int i = 0; i < 6; i++)
        begin
            w = words[i];
            ep = w[7] ? PWR_SHUTDOWN : (w[6] ? PWR_ACTIVE : PWR_STANDBY);
            em = !w[4] ? INTERP_NONE : (w[5] ? INTERP_X4 : INTERP_X2);
            ddc_host_model_inst.ctrl_write(w);
            chk("power", pwr, ep);
            chk("mode", mode, em);
            chk("trim", trim, w[3:0]);
            chk("steps", steps, 5'(5'h08 - w[3:0]));
            apb(1'b0, REG_CONTROL, 32'h0, rd, e);
            chk("ctrl", rd, {24'h0, w});
            if (i == 1 || i == 5)
            begin
                chk("unsettled", settled, 1'b0);
                repeat (i == 1 ? WAKE_CYCLES : SIM_SETTLE) @(posedge pclk);
                chk("settled", settled, 1'b1);
            end
        end
        apb(1'b1, REG_CONTROL, 32'h5C, rd, e);
        repeat (3) @(posedge pclk);
        chk("apb mode", mode, INTERP_X2);
        chk("apb trim", trim, 4'hC);
        apb(1'b0, 12'h010, 32'h0, rd, e);
        chk("bad err", e, 1'b1);
        chk("bad data", rd, 32'h0);
        apb(1'b1, REG_CONTROL, 32'h60, rd, e);
        apb(1'b0, REG_STATUS, 32'h0, rd, e);
        chk("status", rd, 32'h03);
        chk("status err", e, 1'b0);
        apb(1'b1, REG_STATUS, 32'h1, rd, e);
        apb(1'b0, REG_STATUS, 32'h0, rd, e);
        chk("status clr", rd, 32'h02);
        apb(1'b1, REG_CLOCK_DIV, 32'h1, rd, e);
        while (dclk !== 1'b1) @(posedge pclk);
        while (dclk !== 1'b0) @(posedge pclk);
        @(posedge pclk);
        chk("dclk low", dclk, 1'b0);
        @(posedge pclk);
        chk("dclk high", dclk, 1'b1);
        ddc_host_model_inst.samples(10'h2A5, 10'h15A, 1'b0);
        repeat (40) @(posedge pclk);
        chk("out a", out_a, 10'h2A5);
        chk("out b", out_b, 10'h15A);
        apb(1'b0, REG_SAMPLES, 32'h0, rd, e);
        chk("samples", rd, {6'h0, 10'h15A, 6'h0, 10'h2A5});
        ddc_host_model_inst.samples(10'h0F3, 10'h30C, 1'b1);
        repeat (40) @(posedge pclk);
        chk("il a", out_a, 10'h0F3);
        chk("il b", out_b, 10'h0F3);
        complete_run();
    end
endmodule // ddc_top_tb
`default_nettype wire
